// ===== common/dcs_pkg.sv
// Constants, field layout and error carrier for the disk command/status word
`default_nettype none

package dcs_pkg;

  // Field positions inside the command/status word
  localparam int FC_LSB  = 1;   // Function code, three bits
  localparam int EXT_LSB = 4;   // Extended bus address bits 16 and 17
  localparam int IRQ_EN_BIT = 6;   // Interrupt enable
  localparam int RDY_BIT = 7;   // Controller ready
  localparam int DS_LSB  = 8;   // Drive select, two bits

  // Reset and initialize values
  localparam logic [2:0] FC_RST  = 3'h0;
  localparam logic [1:0] DS_RST  = 2'h0;
  localparam logic [1:0] EXT_RST = 2'h0;
  localparam logic       IRQ_EN_RST = 1'b0;
  localparam logic       RDY_RST = 1'b1;

  // Synchronised pin vector {drive_error, drive_ready, bus_init_line_b}
  localparam logic [2:0] PIN_RST = 3'h1;

  // Error codes reported in bits 10 to 13
  localparam logic [3:0] EC_NONE          = 4'h0;
  localparam logic [3:0] EC_OP_INCOMPLETE = 4'h1;
  localparam logic [3:0] EC_DATA_CHECK    = 4'h2;
  localparam logic [3:0] EC_HEADER_CHECK  = 4'h3;
  localparam logic [3:0] EC_LATE          = 4'h4;
  localparam logic [3:0] EC_HDRMIS        = 4'h5;
  localparam logic [3:0] EC_NO_REPLY      = 4'h8;
  localparam logic [3:0] EC_PARITY        = 4'h9;

  // Operation-incomplete timeout
  localparam int unsigned TIMEOUT_MS     = 550;
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);

  // Error pulses raised by the data path, DMA and drive logic
  typedef struct packed {
    logic memory_parity_abort;
    logic no_memory_reply;
    logic header_missing;
    logic data_late;
    logic header_check_fail;
    logic data_check_fail;
  } dcs_err_s;

  // Fixed priority encoder from error pulses to the reported code
  function automatic logic [3:0] err_code_of(input dcs_err_s e, input logic op_incomplete);
    logic [3:0] c;
    c = EC_NONE;
    if (e.memory_parity_abort)    c = EC_PARITY;
    else if (e.no_memory_reply)   c = EC_NO_REPLY;
    else if (e.data_check_fail)   c = EC_DATA_CHECK;
    else if (e.header_check_fail) c = EC_HEADER_CHECK;
    else if (e.data_late)         c = EC_LATE;
    else if (e.header_missing)    c = EC_HDRMIS;
    else if (op_incomplete)       c = EC_OP_INCOMPLETE;
    return c;
  endfunction

endpackage

`default_nettype wire

// ===== core/dcs_op_timer.sv
// Operation-incomplete watchdog counting clock cycles while a command runs
`timescale 1ns/1ps
`default_nettype none

module dcs_op_timer #(
  parameter int unsigned CYCLES = dcs_pkg::TIMEOUT_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      expired
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt;  // Cycles spent in the current command

  // Count while running, hold at the limit, restart when idle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
    end else if (!run) begin
      cnt <= '0;
    end else if (cnt != CW'(CYCLES)) begin
      cnt <= cnt + CW'(1);
    end
  end

  // One pulse when the last allowed cycle has gone by
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      expired <= 1'b0;
    end else begin
      expired <= run && (cnt == CW'(CYCLES - 1));
    end
  end

endmodule

`default_nettype wire

// ===== core/dcs_command_status.sv
// Command/status word of the disk controller: fields, start, completion, errors, interrupt
`timescale 1ns/1ps
`default_nettype none

module dcs_command_status #(
  parameter int unsigned OP_TIMEOUT_CYCLES = dcs_pkg::TIMEOUT_CYCLES
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic            bus_init_line_b,
  input  wire logic            cmd_word_wr,
  input  wire logic [15:0]     cmd_word_wdata,
  input  wire logic            ext_reg_wr,
  input  wire logic [1:0]      ext_reg_wdata,
  input  wire logic            cmd_done,
  input  wire dcs_pkg::dcs_err_s err_in,
  input  wire logic            drive_ready_pin,
  input  wire logic            drive_error_pin,
  input  wire logic            irq_ack,
  output logic [15:0]          rd_data,
  output logic [2:0]           function_code,
  output logic [1:0]           drive_sel,
  output logic [1:0]           ext_addr,
  output logic                 controller_ready,
  output logic                 cmd_start,
  output logic                 irq_req
);

  logic [2:0] pin_s1;      // First synchroniser stage
  logic [2:0] pin_s2;      // Second stage
  logic [2:0] pin_s3;      // Third stage
  logic [2:0] pin_q;       // Settled pin levels
  logic       bus_init;    // Bus initialize active
  logic       drive_ready; // Selected drive ready
  logic       drive_error; // Selected drive flagged an error
  logic       irq_enable;  // Interrupt enable bit
  logic [3:0] error_code;  // Controller error code
  logic       wr_ok;       // Accepted command word write
  logic       ext_ok;      // Accepted extension write
  logic       start;       // Write that clears the ready flag
  logic       expired;     // Timeout pulse
  logic       fail;        // Any error while busy
  logic       done_evt;    // Command ends this cycle
  logic [3:0] next_code;   // Code captured on failure

  // Three-stage synchroniser for pins from outside the clock domain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= dcs_pkg::PIN_RST;
      pin_s2 <= dcs_pkg::PIN_RST;
      pin_s3 <= dcs_pkg::PIN_RST;
    end else begin
      pin_s1 <= {drive_error_pin, drive_ready_pin, bus_init_line_b};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_q <= dcs_pkg::PIN_RST;
    end else begin
      pin_q <= ((pin_s2 ~^ pin_s3) & pin_s2) | ((pin_s2 ^ pin_s3) & pin_q);
    end
  end

  assign bus_init    = !pin_q[0];
  assign drive_ready = pin_q[1];
  assign drive_error = pin_q[2];

  // Writes only land while the controller is ready
  assign wr_ok    = cmd_word_wr && controller_ready && !bus_init;
  assign ext_ok   = ext_reg_wr && controller_ready && !bus_init;
  assign start    = wr_ok && !cmd_word_wdata[dcs_pkg::RDY_BIT];
  assign fail     = !controller_ready && ((|err_in) || expired);
  assign done_evt = !controller_ready && !bus_init && (cmd_done || fail);
  assign next_code = dcs_pkg::err_code_of(err_in, expired);

  // Watchdog runs for as long as a command is in progress
  dcs_op_timer #(
    .CYCLES (OP_TIMEOUT_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .run     (!controller_ready),
    .expired (expired)
  );

  // Function code, drive select and interrupt enable fields
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      function_code <= dcs_pkg::FC_RST;
      drive_sel     <= dcs_pkg::DS_RST;
      irq_enable    <= dcs_pkg::IRQ_EN_RST;
    end else if (bus_init) begin
      function_code <= dcs_pkg::FC_RST;
      drive_sel     <= dcs_pkg::DS_RST;
      irq_enable    <= dcs_pkg::IRQ_EN_RST;
    end else if (wr_ok) begin
      function_code <= cmd_word_wdata[dcs_pkg::FC_LSB +: 3];
      drive_sel     <= cmd_word_wdata[dcs_pkg::DS_LSB +: 2];
      irq_enable    <= cmd_word_wdata[dcs_pkg::IRQ_EN_BIT];
    end
  end

  // Address bits 16 and 17, shared with the extension register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_addr <= dcs_pkg::EXT_RST;
    end else if (bus_init) begin
      ext_addr <= dcs_pkg::EXT_RST;
    end else if (ext_ok) begin
      ext_addr <= ext_reg_wdata;  // Extension write wins a same-cycle clash
    end else if (wr_ok) begin
      ext_addr <= cmd_word_wdata[dcs_pkg::EXT_LSB +: 2];
    end
  end

  // Ready flag: cleared by software only, set by hardware only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      controller_ready <= dcs_pkg::RDY_RST;
    end else if (bus_init) begin
      controller_ready <= 1'b1;
    end else if (start) begin
      controller_ready <= 1'b0;
    end else if (done_evt) begin
      controller_ready <= 1'b1;
    end
  end

  // One-cycle start pulse toward the sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_start <= 1'b0;
    end else begin
      cmd_start <= start && !bus_init;
    end
  end

  // Error code: cleared per command, first failure captured
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      error_code <= dcs_pkg::EC_NONE;
    end else if (bus_init || start) begin
      error_code <= dcs_pkg::EC_NONE;
    end else if (fail) begin
      error_code <= next_code;
    end
  end

  // Interrupt request: set on enabled completion, held until acknowledge or bus initialize
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
    end else if (bus_init) begin
      irq_req <= 1'b0;
    end else if (done_evt && irq_enable) begin
      irq_req <= 1'b1;
    end else if (irq_ack) begin
      irq_req <= 1'b0;
    end
  end

  // Read word snapshot; composite error from bits 10 to 14
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= {(|error_code) | drive_error, drive_error, error_code, drive_sel,
                  controller_ready, irq_enable, ext_addr, function_code, drive_ready};
    end
  end

  a_start_clears_rdy: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    start && !bus_init |=> !controller_ready && cmd_start)
    else $error("start did not clear ready");

  a_init_clears_fc: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    bus_init |=> function_code == dcs_pkg::FC_RST && irq_enable == 1'b0 && controller_ready)
    else $error("initialize did not clear fields");

  a_ext_from_write: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    wr_ok && !ext_ok |=> ext_addr == $past(cmd_word_wdata[5:4]))
    else $error("extended address not written");

  a_irq_on_done: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    done_evt && irq_enable |=> irq_req ##1 (irq_req || $past(irq_ack) || $past(bus_init)))
    else $error("no interrupt at command end");

  a_irq_held: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    irq_req && !irq_ack && !bus_init |=> irq_req)
    else $error("interrupt dropped before acknowledge");

  a_done_sets_rdy: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    done_evt |=> controller_ready ##2 rd_data[7] || $past(start, 2) || $past(bus_init, 2))
    else $error("ready not set at command end");

  a_busy_locked: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !controller_ready && !done_evt && !bus_init |=> !controller_ready && $stable(drive_sel))
    else $error("ready or field changed while busy");

  a_code_on_fail: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    fail && !bus_init |=> error_code == dcs_pkg::err_code_of($past(err_in), $past(expired)))
    else $error("wrong error code captured");

  a_timeout_code: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    expired && !controller_ready && !bus_init && err_in == '0 |=> error_code == dcs_pkg::EC_OP_INCOMPLETE)
    else $error("timeout not reported");

  a_crc_code: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    fail && !bus_init && err_in == 6'h01 |=> error_code == dcs_pkg::EC_DATA_CHECK)
    else $error("data check failure not reported");

  a_start_clears_ec: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    cmd_start |-> error_code == dcs_pkg::EC_NONE)
    else $error("error code not cleared at start");

  a_composite_err: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rd_data[15] == (|rd_data[14:10]))
    else $error("composite error bit wrong");

  a_clean_done: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    done_evt && !fail |=> error_code == dcs_pkg::EC_NONE)
    else $error("clean command left an error code");

endmodule

`default_nettype wire

// ===== test/dcs_host_model.sv
// Host-side model that acknowledges interrupt requests after a set delay
`timescale 1ns/1ps
`default_nettype none

module dcs_host_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       irq_req,
  input  wire logic       ack_en,
  input  wire logic [3:0] dly,
  output logic            irq_ack
);
  logic [3:0] wait_cnt;  // Cycles the pending request has been seen

  // One acknowledge pulse per request, dly cycles after it is seen
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 4'h0;
      irq_ack  <= 1'b0;
    end else if (irq_req && ack_en && !irq_ack) begin
      wait_cnt <= wait_cnt + 4'h1;
      irq_ack  <= (wait_cnt == dly);
    end else begin
      wait_cnt <= 4'h0;
      irq_ack  <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the command/status word against an integer model
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic              sys_clk, rst_b, bus_init_line_b, cmd_word_wr, ext_reg_wr, cmd_done, irq_ack, ack_en;
  logic              drive_ready_pin, drive_error_pin;
  logic [15:0]       cmd_word_wdata, rd_data;
  logic [1:0]        ext_reg_wdata, drive_sel, ext_addr;
  logic [2:0]        function_code;
  logic              controller_ready, cmd_start, irq_req;
  logic [3:0]        dly;
  dcs_pkg::dcs_err_s err_in;
  int                n_fail, checks, cyc, fc, ds, ext, irq_en, code, rdy, dr, de, n, i;
  int                codes[6] = '{2, 3, 4, 5, 8, 9};  // Code of each error pulse, LSB first

  dcs_command_status #(.OP_TIMEOUT_CYCLES(50)) dcs_command_status_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .bus_init_line_b(bus_init_line_b), .cmd_word_wr(cmd_word_wr),
    .cmd_word_wdata(cmd_word_wdata), .ext_reg_wr(ext_reg_wr), .ext_reg_wdata(ext_reg_wdata),
    .cmd_done(cmd_done), .err_in(err_in), .drive_ready_pin(drive_ready_pin),
    .drive_error_pin(drive_error_pin), .irq_ack(irq_ack),
    .rd_data(rd_data), .function_code(function_code), .drive_sel(drive_sel), .ext_addr(ext_addr),
    .controller_ready(controller_ready), .cmd_start(cmd_start), .irq_req(irq_req));

  dcs_host_model dcs_host_model_inst (.sys_clk(sys_clk), .rst_b(rst_b), .irq_req(irq_req),
    .ack_en(ack_en), .dly(dly), .irq_ack(irq_ack));

  // Expected word from the model
  function automatic logic [15:0] word(input int r);
    return {code != 0 || de != 0, de[0], code[3:0], ds[1:0], r[0], irq_en[0], ext[1:0], fc[2:0], dr[0]};
  endfunction

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Count report and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Write all writable fields; go clears the ready bit to start a command
  task automatic wrf(input int f, input int e, input int en_v, input int d, input int go);
    int was;
    was = rdy;
    @(posedge sys_clk);
    cmd_word_wr    <= 1'b1;
    cmd_word_wdata <= {6'h00, d[1:0], go == 0, en_v[0], e[1:0], f[2:0], 1'b0};
    @(posedge sys_clk);
    cmd_word_wr <= 1'b0;
    #1;
    if (rdy) begin
      {fc, ext, irq_en, ds} = {f, e, en_v, d};
      if (go) {rdy, code} = {32'h0, 32'h0};
    end
    chk(cmd_start, go && was);
    chk(function_code, fc);
    @(posedge sys_clk);
    #1;
    chk(rd_data, word(rdy));
  endtask

  // End a running command with error pulses or a completion
  task automatic endcmd(input dcs_pkg::dcs_err_s e, input logic done, input int c);
    @(posedge sys_clk);
    err_in   <= e;
    cmd_done <= done;
    @(posedge sys_clk);
    err_in   <= '0;
    cmd_done <= 1'b0;
    #1;
    {rdy, code} = {32'h1, c};
    chk(controller_ready, 1'b1);
    chk(irq_req, irq_en[0]);
    @(posedge sys_clk);
    #1;
    chk(rd_data, word(1));
    for (n = 0; n < 20 && ack_en && irq_req !== 1'b0; n++) @(posedge sys_clk);
  endtask

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    {rst_b, cmd_word_wr, ext_reg_wr, cmd_done, cmd_word_wdata, ext_reg_wdata, err_in, cyc} = '0;
    {drive_ready_pin, drive_error_pin} = 2'h0;
    {bus_init_line_b, ack_en, dly} = {1'b1, 1'b1, 4'h2};
    {fc, ds, ext, irq_en, code, rdy} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    void'($urandom(32'h9621_671f));
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(rd_data, 16'h0080);
    repeat (4) wrf($urandom % 8, $urandom % 4, $urandom % 2, $urandom % 4, 0);
    $display("test fields done");
    for (i = 0; i < 8; i++) begin
      dly <= 4'($urandom % 4 + 1);
      wrf($urandom % 8, $urandom % 4, 1, $urandom % 4, 1);
      wrf(7, 3, 0, 3, 0);
      if (i < 6) endcmd(dcs_pkg::dcs_err_s'(6'(1 << i)), 1'b0, codes[i]);
      else if (i == 6) endcmd(6'h3F, 1'b0, 9);
      else endcmd('0, 1'b1, 0);
    end
    $display("test errors done");
    wrf(1, 0, 0, 2, 1);
    for (n = 0; n < 80 && controller_ready !== 1'b1; n++) @(posedge sys_clk);
    chk(n >= 44 && n <= 52, 1'b1);
    {rdy, code} = {32'h1, 32'h1};
    @(posedge sys_clk);
    #1;
    chk(rd_data, word(1));
    $display("test timeout done");
    ack_en <= 1'b0;
    wrf(2, 1, 1, 1, 1);
    endcmd('0, 1'b1, 0);
    wrf(2, 1, 0, 1, 0);
    repeat (3) @(posedge sys_clk);
    chk(irq_req, 1'b1);
    ack_en <= 1'b1;
    for (n = 0; n < 20 && irq_req !== 1'b0; n++) @(posedge sys_clk);
    chk(irq_req, 1'b0);
    $display("test irq hold done");
    @(posedge sys_clk);
    ext_reg_wr    <= 1'b1;
    ext_reg_wdata <= 2'h2;
    @(posedge sys_clk);
    ext_reg_wr <= 1'b0;
    ext = 2;
    @(posedge sys_clk);
    #1;
    chk(ext_addr, 2'h2);
    $display("test extension done");
    @(posedge sys_clk);
    drive_ready_pin <= 1'b1;
    drive_error_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    {dr, de} = {32'h1, 32'h1};
    chk(rd_data, word(1));
    @(posedge sys_clk);
    drive_ready_pin <= 1'b0;
    drive_error_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    {dr, de} = {32'h0, 32'h0};
    chk(rd_data, word(1));
    $display("test drive pins done");
    ack_en <= 1'b0;
    wrf(5, 3, 1, 2, 1);
    endcmd(6'h01, 1'b0, 2);
    wrf(6, 1, 1, 3, 1);
    @(posedge sys_clk);
    bus_init_line_b <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    {fc, ds, ext, irq_en, code, rdy} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    chk(rd_data, word(1));
    chk(irq_req, 1'b0);
    @(posedge sys_clk);
    bus_init_line_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    $display("test initialize done");
    summarize();
  end
endmodule

`default_nettype wire
